// ===== bench/sfa_core_chk.sv
`timescale 1ns/10ps
`default_nettype none

module sfa_core_chk (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        reset_n,
  // Avalon-MM slave.
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  // All checks run on the core clock and pause during reset.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // A request seen by a waiting slave, its answer, and a read answer.
  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest;
  endsequence
  sequence s_rd_ans(a);
    s_ans ##0 (avs_read && avs_address == a);
  endsequence

  // Bus answers, unmapped reads, register widths and the busy bit.
  property p_answer;
    s_take |-> ##[1:4] s_ans;
  endproperty
  property p_one;
    s_ans |=> avs_waitrequest;
  endproperty
  property p_quiet;
    !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_exec;
    s_ans ##0 (avs_write && avs_address == 8'h00) |=> avs_waitrequest[*2];
  endproperty
  property p_hold;
    !avs_read |=> $stable(avs_readdata);
  endproperty
  property p_unmapped;
    s_rd_ans(8'h24) |-> avs_readdata == 32'h0;
  endproperty
  property p_acc;
    s_rd_ans(8'h04) |-> avs_readdata[31:8] == 24'h0;
  endproperty
  property p_state;
    s_rd_ans(8'h20) |-> avs_readdata[0] == 1'b0;
  endproperty
  property p_flags;
    s_rd_ans(8'h08) |-> avs_readdata[31:5] == 27'h0000000;
  endproperty

  a_answer: assert property (p_answer) else $error("no answer");
  a_one: assert property (p_one) else $error("long answer");
  a_quiet: assert property (p_quiet) else $error("stray answer");
  a_exec: assert property (p_exec) else $error("no exec stall");
  a_hold: assert property (p_hold) else $error("readdata moved");
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  a_acc: assert property (p_acc) else $error("acc width");
  a_state: assert property (p_state) else $error("busy seen");
  a_flags: assert property (p_flags) else $error("flags width");
endmodule // sfa_core_chk

bind sfa_core sfa_core_chk u_chk (
  .clock(clock), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

`default_nettype wire

// ===== bench/sfa_core_tb_top.sv
`include "sfa_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module sfa_core_tb_top;
  logic        clock = 1'b0;
  logic        reset_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  int          num_errors = 0;
  int          checks = 0;

  // Core clock at 250 MHz.
  always #2 clock = ~clock;

  sfa_core dut (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  sfa_sub_model u_model ();

  // Prints the counts and the verdict, then stops.
  task finish_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // One Avalon access: hold until waitrequest is sampled low.
  // Only the watchdog ends a wait that never gets an answer.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clock);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do
      @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  // Runs one file subtraction and checks accumulator, memory and flags.
  task file_op(input logic d, input logic a, input logic [7:0] f,
    input logic ext, input logic [11:0] idx, input logic [7:0] mv,
    input logic [7:0] w);
    logic [12:0] e;
    logic [11:0] ad;
    ad = u_model.ea(a, ext, f, 4'h2, idx);
    e = u_model.sub(mv, w);
    wr(`SFA_OFS_CONFIG, 32'(ext));
    wr(`SFA_OFS_BANK, 32'h2);
    wr(`SFA_OFS_INDEX, 32'(idx));
    wr(`SFA_OFS_MEM_ADDR, 32'(ad));
    wr(`SFA_OFS_MEM_DATA, 32'(mv));
    wr(`SFA_OFS_ACC, 32'(w));
    wr(`SFA_OFS_INSTR, 32'({6'h17, d, a, f}));
    rd(`SFA_OFS_ACC, 32'(d ? w : e[7:0]));
    rd(`SFA_OFS_MEM_DATA, 32'(d ? e[7:0] : mv));
    rd(`SFA_OFS_FLAGS, 32'(e[12:8]));
  endtask

  // One immediate subtraction, then accumulator and flags against the model.
  task imm_case(input logic [7:0] k, input logic [7:0] w);
    logic [12:0] e;
    e = u_model.sub(k, w);
    wr(`SFA_OFS_ACC, 32'(w));
    wr(`SFA_OFS_INSTR, 32'({8'h08, k}));
    rd(`SFA_OFS_ACC, 32'(e[7:0]));
    rd(`SFA_OFS_FLAGS, 32'(e[12:8]));
  endtask

  // Immediate minus accumulator over sign, zero, borrow and nibble cases.
  task t_imm;
    imm_case(8'h02, 8'h01);
    imm_case(8'h02, 8'h02);
    imm_case(8'h02, 8'h03);
    imm_case(8'h80, 8'h01);
    imm_case(8'h10, 8'h01);
    $display("test imm done");
  endtask

  // Both destinations through the banked page.
  task t_dest;
    file_op(1'b0, 1'b1, 8'h34, 1'b0, 12'h0, 8'h03, 8'h02);
    file_op(1'b1, 1'b1, 8'h34, 1'b0, 12'h0, 8'h01, 8'h02);
    $display("test dest done");
  endtask

  // Fixed access bank, low and high halves.
  task t_access;
    file_op(1'b1, 1'b0, 8'h10, 1'b0, 12'h300, 8'h80, 8'h01);
    file_op(1'b0, 1'b0, 8'h90, 1'b0, 12'h300, 8'h22, 8'h22);
    $display("test access done");
  endtask

  // Indexed offset at the limit and just above it.
  task t_index;
    file_op(1'b1, 1'b0, 8'h5F, 1'b1, 12'h300, 8'h45, 8'h15);
    file_op(1'b1, 1'b0, 8'h60, 1'b1, 12'h300, 8'h07, 8'h09);
    $display("test index done");
  endtask

  // Unmapped read, an opcode that is neither subtraction, and a write
  // whose low byte lane is disabled; the accumulator keeps its last value.
  task t_misc;
    rd(8'h24, 32'h0);
    wr(`SFA_OFS_INSTR, 32'hFFFF);
    rd(`SFA_OFS_STATE, 32'h2);
    rd(`SFA_OFS_ACC, 32'h09);
    avs_byteenable <= 4'hE;
    wr(`SFA_OFS_ACC, 32'h55);
    avs_byteenable <= 4'hF;
    rd(`SFA_OFS_ACC, 32'h09);
    $display("test misc done");
  endtask

  // Reset, then the scenarios in order.
  initial
  begin
    reset_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    t_imm();
    t_dest();
    t_access();
    t_index();
    t_misc();
    finish_test();
  end

  // Watchdog that cuts a hang short.
  initial
  begin
    #40000;
    num_errors++;
    finish_test();
  end
endmodule // sfa_core_tb_top

`default_nettype wire

// ===== bench/sfa_sub_model.sv
`timescale 1ns/10ps
`default_nettype none

module sfa_sub_model;
  // Reference subtraction: flags {N,OV,Z,DC,C} above the result byte.
  function automatic logic [12:0] sub(input logic [7:0] m,
    input logic [7:0] s);
    logic [7:0] r;
    logic       ov;
    r = m - s;
    ov = (m[7] != s[7]) && (r[7] != m[7]);
    return {r[7], ov, r == 8'h00, m[3:0] >= s[3:0], m >= s, r};
  endfunction

  // Data-memory address that a file operand resolves to.
  function automatic logic [11:0] ea(input logic a, input logic ext,
    input logic [7:0] f, input logic [3:0] bank, input logic [11:0] idx);
    if (a)
      return {bank, f};
    if (ext && f <= 8'h5F)
      return idx + 12'(f);
    return (f < 8'h80) ? {4'h0, f} : {4'hF, f};
  endfunction
endmodule // sfa_sub_model

`default_nettype wire

// ===== hw/sfa_core.sv
`include "sfa_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module sfa_core
  import sfa_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Avalon-MM slave.
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);

  localparam int DEPTH = 1 << ADDR_W;

  // Architectural and control state.
  sfa_state_t        state_q;
  logic [15:0]       instr_q;
  logic [7:0]        acc_q;
  logic [4:0]        flags_q;
  logic [3:0]        bank_q;
  logic              ext_q;
  logic [ADDR_W-1:0] index_q;
  logic [ADDR_W-1:0] mem_addr_q;
  logic              illegal_q;
  logic [7:0]        operand_q;
  logic [ADDR_W-1:0] target_q;
  logic              wait_q;
  logic [31:0]       rdata_q;

  // Data memory behind the subtract instructions.
  logic [7:0]        dmem [DEPTH];

  // Bus handshake decode.
  wire logic        take     = (avs_read || avs_write) && wait_q &&
                               (state_q == SFA_IDLE);
  wire logic        wr_take  = take && avs_write;
  wire logic [31:0] be_mask  = {{8{avs_byteenable[3]}},
                                {8{avs_byteenable[2]}},
                                {8{avs_byteenable[1]}},
                                {8{avs_byteenable[0]}}};
  wire logic        sel_instr = (avs_address == `SFA_OFS_INSTR);
  wire logic        sel_acc   = (avs_address == `SFA_OFS_ACC);
  wire logic        sel_flags = (avs_address == `SFA_OFS_FLAGS);
  wire logic        sel_bank  = (avs_address == `SFA_OFS_BANK);
  wire logic        sel_cfg   = (avs_address == `SFA_OFS_CONFIG);
  wire logic        sel_index = (avs_address == `SFA_OFS_INDEX);
  wire logic        sel_maddr = (avs_address == `SFA_OFS_MEM_ADDR);
  wire logic        sel_mdata = (avs_address == `SFA_OFS_MEM_DATA);
  wire logic        sel_state = (avs_address == `SFA_OFS_STATE);

  // Byte-lane merged write values for the instruction, accumulator, flags, bank, index and memory address registers.
  wire logic [31:0] wr_instr = ({16'h0000, instr_q} & ~be_mask) |
                               (avs_writedata & be_mask);
  wire logic [31:0] wr_acc   = ({24'h000000, acc_q} & ~be_mask) |
                               (avs_writedata & be_mask);
  wire logic [31:0] wr_flags = ({27'h0000000, flags_q} & ~be_mask) |
                               (avs_writedata & be_mask);
  wire logic [31:0] wr_bank  = ({28'h0000000, bank_q} & ~be_mask) |
                               (avs_writedata & be_mask);
  wire logic [31:0] wr_index = ({{(32-ADDR_W){1'b0}}, index_q} & ~be_mask) |
                               (avs_writedata & be_mask);
  wire logic [31:0] wr_maddr = ({{(32-ADDR_W){1'b0}}, mem_addr_q} &
                                ~be_mask) | (avs_writedata & be_mask);
  wire logic        wr_any_lo = avs_byteenable[0] || avs_byteenable[1];

  // Read data selection; unmapped offsets read as zero.
  wire logic [31:0] rd_mux =
    sel_instr ? {16'h0000, instr_q} :
    sel_acc   ? {24'h000000, acc_q} :
    sel_flags ? {27'h0000000, flags_q} :
    sel_bank  ? {28'h0000000, bank_q} :
    sel_cfg   ? {31'h00000000, ext_q} :
    sel_index ? {{(32-ADDR_W){1'b0}}, index_q} :
    sel_maddr ? {{(32-ADDR_W){1'b0}}, mem_addr_q} :
    sel_mdata ? {24'h000000, dmem[mem_addr_q]} :
    sel_state ? {30'h00000000, illegal_q, 1'b0} :
    32'h00000000;

  // Opcode decode of the held instruction.
  wire logic       is_imm  = (instr_q[15:8] == `SFA_OP_IMM_HI);
  wire logic       is_file = (instr_q[15:10] == `SFA_OP_FILE_HI);
  wire sfa_kind_t  kind    = is_imm  ? SFA_KIND_IMM :
                             is_file ? SFA_KIND_FILE : SFA_KIND_NONE;
  wire logic       dest_file = instr_q[`SFA_OP_D_BIT];
  wire logic       bank_sel  = instr_q[`SFA_OP_A_BIT];
  wire logic [7:0] file_addr = instr_q[7:0];

  // Data-memory address formation for the file operand.
  wire logic [ADDR_W-1:0] addr_banked =
    ADDR_W'({bank_q, file_addr});
  wire logic [ADDR_W-1:0] addr_indexed =
    ADDR_W'(index_q + {{(ADDR_W-8){1'b0}}, file_addr});
  wire logic [ADDR_W-1:0] addr_access =
    (file_addr < `SFA_ACCESS_SPLIT) ?
      ADDR_W'({`SFA_ACCESS_LO_BANK, file_addr}) :
      ADDR_W'({`SFA_ACCESS_HI_BANK, file_addr});
  wire logic              use_index = ext_q &&
                                      (file_addr <= `SFA_INDEX_LIMIT);
  wire logic [ADDR_W-1:0] file_ea =
    bank_sel  ? addr_banked :
    use_index ? addr_indexed : addr_access;

  // Subtraction datapath: operand minus accumulator.
  logic [7:0] alu_res;
  logic       alu_n;
  logic       alu_ov;
  logic       alu_c;
  logic       alu_dc;
  logic       alu_z;

  sfa_sub_alu u_alu (
    .minuend         (operand_q),
    .subtrahend      (acc_q),
    .result          (alu_res),
    .negative        (alu_n),
    .overflow        (alu_ov),
    .no_borrow       (alu_c),
    .digit_no_borrow (alu_dc),
    .zero            (alu_z)
  );

  wire logic [4:0] alu_flags = {alu_n, alu_ov, alu_z, alu_dc, alu_c};
  wire logic       exec_now  = (state_q == SFA_EXEC);
  wire logic       to_acc    = exec_now &&
                               ((kind == SFA_KIND_IMM) || !dest_file);
  wire logic       to_file   = exec_now && (kind == SFA_KIND_FILE) &&
                               dest_file;

  // Bus answer: waitrequest drops for one cycle after a request is taken.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wait_q <= !take;
      if (take && avs_read)
        rdata_q <= rd_mux;
    end
  end

  // Sequencer: a write to the instruction register starts execution.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= SFA_IDLE;
    else
    begin
      case (state_q)
        SFA_IDLE:
          if (wr_take && sel_instr && wr_any_lo)
            state_q <= SFA_FETCH;
        SFA_FETCH:
          state_q <= (kind == SFA_KIND_NONE) ? SFA_IDLE : SFA_EXEC;
        SFA_EXEC:
          state_q <= SFA_IDLE;
        default:
          state_q <= SFA_IDLE;
      endcase
    end
  end

  // Operand fetch: literal for the immediate form, memory byte otherwise.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      operand_q <= 8'h00;
      target_q  <= '0;
    end
    else if (state_q == SFA_FETCH)
    begin
      operand_q <= is_imm ? instr_q[7:0] : dmem[file_ea];
      target_q  <= file_ea;
    end
  end

  // Instruction, illegal-opcode and configuration registers.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      instr_q    <= `SFA_RST_INSTR;
      illegal_q  <= 1'b0;
      bank_q     <= `SFA_RST_BANK;
      ext_q      <= 1'b0;
      index_q    <= `SFA_RST_INDEX;
      mem_addr_q <= '0;
    end
    else
    begin
      if (wr_take && sel_instr)
        instr_q <= wr_instr[15:0];
      if (state_q == SFA_FETCH)
        illegal_q <= (kind == SFA_KIND_NONE);
      if (wr_take && sel_bank)
        bank_q <= wr_bank[3:0];
      if (wr_take && sel_cfg && avs_byteenable[0])
        ext_q <= avs_writedata[`SFA_CFG_EXT];
      if (wr_take && sel_index)
        index_q <= wr_index[ADDR_W-1:0];
      if (wr_take && sel_maddr)
        mem_addr_q <= wr_maddr[ADDR_W-1:0];
    end
  end

  // Accumulator and flags: execution writes the flags and, except for a file destination, the accumulator; software may preset them.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_q   <= `SFA_RST_ACC;
      flags_q <= `SFA_RST_FLAGS;
    end
    else
    begin
      if (to_acc)
        acc_q <= alu_res;
      else if (wr_take && sel_acc)
        acc_q <= wr_acc[7:0];
      if (exec_now)
        flags_q <= alu_flags;
      else if (wr_take && sel_flags)
        flags_q <= wr_flags[4:0];
    end
  end

  // Data memory writes: file destination or software through the window.
  always_ff @(posedge clock)
  begin
    if (to_file)
      dmem[target_q] <= alu_res;
    else if (wr_take && sel_mdata && avs_byteenable[0])
      dmem[mem_addr_q] <= avs_writedata[7:0];
  end

  // Outputs straight from flip-flops.
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

endmodule // sfa_core

`default_nettype wire

// ===== hw/sfa_sub_alu.sv
`timescale 1ns/10ps
`default_nettype none

module sfa_sub_alu
  import sfa_pkg::*;
(
  // Operands.
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  // Result and flags.
  output logic      [7:0] result,
  output logic            negative,
  output logic            overflow,
  output logic            no_borrow,
  output logic            digit_no_borrow,
  output logic            zero
);

  logic [8:0] full_sum;
  logic [4:0] nib_sum;

  // Two's-complement subtraction as minuend plus inverted subtrahend plus one.
  assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
  assign nib_sum  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;

  // Flags follow the arithmetic; carry set means no borrow occurred.
  assign result          = full_sum[7:0];
  assign no_borrow       = full_sum[8];
  assign digit_no_borrow = nib_sum[4];
  assign negative        = full_sum[7];
  assign zero            = (full_sum[7:0] == 8'h00);
  assign overflow        = (minuend[7] != subtrahend[7]) &&
                           (full_sum[7] != minuend[7]);

endmodule // sfa_sub_alu

`default_nettype wire

// ===== inc/sfa_pkg.sv
package sfa_pkg;

  // Execution sequencer states.
  typedef enum logic [1:0] {
    SFA_IDLE,
    SFA_FETCH,
    SFA_EXEC
  } sfa_state_t;

  // Which subtraction the current opcode selects.
  typedef enum logic [1:0] {
    SFA_KIND_NONE,
    SFA_KIND_IMM,
    SFA_KIND_FILE
  } sfa_kind_t;

endpackage

// ===== inc/sfa_regs.svh
`ifndef SFA_REGS_SVH
`define SFA_REGS_SVH

// Register byte offsets on the Avalon-MM slave, one aligned word each.
`define SFA_OFS_INSTR      8'h00
`define SFA_OFS_ACC        8'h04
`define SFA_OFS_FLAGS      8'h08
`define SFA_OFS_BANK       8'h0C
`define SFA_OFS_CONFIG     8'h10
`define SFA_OFS_INDEX      8'h14
`define SFA_OFS_MEM_ADDR   8'h18
`define SFA_OFS_MEM_DATA   8'h1C
`define SFA_OFS_STATE      8'h20

// Flag positions in the flags register.
`define SFA_FLAG_C         0
`define SFA_FLAG_DC        1
`define SFA_FLAG_Z         2
`define SFA_FLAG_OV        3
`define SFA_FLAG_N         4

// Bit positions in the config and state registers.
`define SFA_CFG_EXT        0
`define SFA_ST_BUSY        0
`define SFA_ST_ILLEGAL     1

// Opcode patterns.
`define SFA_OP_IMM_HI      8'h08
`define SFA_OP_FILE_HI     6'h17
`define SFA_OP_D_BIT       9
`define SFA_OP_A_BIT       8

// Addressing limits inside the fixed access bank.
`define SFA_INDEX_LIMIT    8'h5F
`define SFA_ACCESS_SPLIT   8'h80
`define SFA_ACCESS_HI_BANK 4'hF
`define SFA_ACCESS_LO_BANK 4'h0

// Reset values.
`define SFA_RST_ACC        8'h00
`define SFA_RST_FLAGS      5'h00
`define SFA_RST_BANK       4'h0
`define SFA_RST_INDEX      12'h000
`define SFA_RST_INSTR      16'h0000

`endif
